// ---- rtl/pump_staging_sleep_control.v ----
/*
  Pump staging, pressure reference handling and automatic sleep/wake control.
  Assumes all inputs come from logic on clk (sensor front end, clock-of-day
  unit, regulator arithmetic); the regulator itself lives outside.
*/
// Chosen here: the register addresses and the address-and-strobe port.
// Contract
// - adding motors closes relays a..d cumulatively; a alone runs motor one variable
// - reducing motors opens relays in reverse, highest first, a released last
// - secondary regulator never drives frequency; reaches analog out only at code 32
// - primary reference and feedback scaled from real units; reference clamped
// - reference and feedback sources selectable; sources one and two combined
// - clock enabled: on working day inside segment, reference becomes segment pressure
// - sleep method 0 lower limit, 1 frequency based, 2 deviation based
// - frequency sleep needs frequency at or below start frequency beyond delay
// - deviation sleep needs feedback past reference by deviation beyond delay
// - after sleep condition, reference boosted by signed value, then sleep
// - at upper limit with feedback short, sleep when longest boost time ends
// - wake after feedback falls short by wake deviation beyond wake delay
// - on wake run at wake frequency; regulator continues from it
`timescale 1ns/1ps
`include "pump_ctrl_defines.vh"
module pump_staging_sleep_control #(
  parameter NUM_MOTORS  = 4,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata_ff,
  input  wire        stage_add,
  input  wire        stage_reduce,
  input  wire [15:0] ref_src_a,
  input  wire [15:0] ref_src_b,
  input  wire [15:0] fb_src_a,
  input  wire [15:0] fb_src_b,
  input  wire [2:0]  day_of_week,
  input  wire [10:0] minute_of_day,
  input  wire [15:0] pri_reg_freq,
  input  wire [15:0] sec_reg_out,
  output wire        relay_out_a,
  output wire        relay_out_b,
  output wire        relay_out_c,
  output wire        relay_out_d,
  output reg  [15:0] pri_ref_pct_ff,
  output wire [15:0] pri_fb_pct,
  output reg  [15:0] freq_cmd_ff,
  output reg         run_en_ff,
  output reg         reg_preset_ff,
  output reg  [15:0] reg_preset_val_ff,
  output reg  [15:0] ao_out_ff
);
  localparam ST_RUN   = 2'h0;
  localparam ST_BOOST = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam ST_WAKE  = 2'h3;

  reg  [31:0] ctrl_ff;
  reg  [31:0] scale_ff;
  reg  [31:0] ref_lim_ff;
  reg  [15:0] ref_key_ff;
  reg  [31:0] sleep_freq_ff;
  reg  [31:0] sleep_dev_ff;
  reg  [31:0] delays_ff;
  reg  [31:0] boost_ff;
  reg  [31:0] seg_ff;
  reg  [31:0] seg_time_ff;
  reg  [7:0]  ao_func_ff;
  reg  [31:0] freq_lim_ff;
  reg  [2:0]  stage_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [31:0] tick_cnt_ff;
  reg         tick_ff;
  reg  [15:0] ref_a;
  reg  [15:0] fb_a;
  reg  [16:0] ref_comb;
  reg  [16:0] fb_comb;
  reg  [15:0] ref_sel;
  reg  [15:0] ref_clamp;
  reg  [15:0] fb_sel;
  reg  [31:0] rd_mux;
  wire [15:0] ref_pct;
  wire        seg_active;
  wire [1:0]  method;
  wire        neg_out;
  wire signed [17:0] dev;
  wire signed [28:0] boost_prod;
  wire signed [28:0] boost_ref;
  wire        sleep_cond;
  wire        sleep_ok;
  wire        boost_timeout;
  wire        boost_reached;
  wire        wake_cond;
  wire        wake_ok;
  wire        wr_stage;
  wire        do_add;
  wire        do_red;
  wire [NUM_MOTORS-1:0] relays;

  assign method  = ctrl_ff[`CTRL_METHOD_HI:`CTRL_METHOD_LO];
  assign neg_out = ctrl_ff[`CTRL_NEG_OUT];

  // register writes; everything software tunes lives here
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff       <= `RST_CTRL;
      scale_ff      <= `RST_SCALE;
      ref_lim_ff    <= `RST_REF_LIM;
      ref_key_ff    <= 16'h0000;
      sleep_freq_ff <= `RST_SLEEP_FREQ;
      sleep_dev_ff  <= `RST_SLEEP_DEV;
      delays_ff     <= `RST_DELAYS;
      boost_ff      <= `RST_BOOST;
      seg_ff        <= 32'h0000_0000;
      seg_time_ff   <= 32'h0000_0000;
      ao_func_ff    <= 8'h00;
      freq_lim_ff   <= `RST_FREQ_LIM;
    end else if (wr_stb) begin
      case (addr)
        `OFS_CTRL:       ctrl_ff       <= wdata;
        `OFS_SCALE:      scale_ff      <= wdata;
        `OFS_REF_LIM:    ref_lim_ff    <= wdata;
        `OFS_REF_KEY:    ref_key_ff    <= wdata[15:0];
        `OFS_SLEEP_FREQ: sleep_freq_ff <= wdata;
        `OFS_SLEEP_DEV:  sleep_dev_ff  <= wdata;
        `OFS_DELAYS:     delays_ff     <= wdata;
        `OFS_BOOST:      boost_ff      <= wdata;
        `OFS_SEG:        seg_ff        <= wdata;
        `OFS_SEG_TIME:   seg_time_ff   <= wdata;
        `OFS_AO_FUNC:    ao_func_ff    <= wdata[7:0];
        `OFS_FREQ_LIM:   freq_lim_ff   <= wdata;
        default:         ao_func_ff    <= ao_func_ff;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always @* begin
    case (addr)
      `OFS_CTRL:       rd_mux = ctrl_ff;
      `OFS_STAGE:      rd_mux = {29'h0, stage_ff};
      `OFS_SCALE:      rd_mux = scale_ff;
      `OFS_REF_LIM:    rd_mux = ref_lim_ff;
      `OFS_REF_KEY:    rd_mux = {16'h0, ref_key_ff};
      `OFS_SLEEP_FREQ: rd_mux = sleep_freq_ff;
      `OFS_SLEEP_DEV:  rd_mux = sleep_dev_ff;
      `OFS_DELAYS:     rd_mux = delays_ff;
      `OFS_BOOST:      rd_mux = boost_ff;
      `OFS_SEG:        rd_mux = seg_ff;
      `OFS_SEG_TIME:   rd_mux = seg_time_ff;
      `OFS_AO_FUNC:    rd_mux = {24'h0, ao_func_ff};
      `OFS_FREQ_LIM:   rd_mux = freq_lim_ff;
      `OFS_STATUS:     rd_mux = {freq_cmd_ff, 9'h0, seg_active, state_ff, 1'b0, stage_ff};
      `OFS_PCT:        rd_mux = {pri_fb_pct, pri_ref_pct_ff};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= rd_stb ? rd_mux : 32'h0000_0000;
    end
  end

  // motor staging: a write to the stage register or a port pulse moves one step
  assign wr_stage = wr_stb && (addr == `OFS_STAGE);
  assign do_add   = stage_add | (wr_stage & wdata[`STAGE_ADD_BIT]);
  assign do_red   = stage_reduce | (wr_stage & wdata[`STAGE_RED_BIT]);

  // add and reduce together cancel; stage never exceeds motor count
  always @(posedge clk) begin
    if (!rst_n) begin
      stage_ff <= 3'h0;
    end else if (do_add && !do_red && stage_ff < NUM_MOTORS[2:0]) begin
      stage_ff <= stage_ff + 3'h1;
    end else if (do_red && !do_add && stage_ff != 3'h0) begin
      stage_ff <= stage_ff - 3'h1;
    end
  end

  // thermometer code: relay i closed while more than i motors are staged
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MOTORS; gi = gi + 1) begin : g_relay
      assign relays[gi] = (stage_ff > gi);
    end
  endgenerate
  assign relay_out_a = relays[0];
  assign relay_out_b = relays[1];
  assign relay_out_c = relays[2];
  assign relay_out_d = relays[3];

  // source selection and combination of sources one and two
  always @* begin
    ref_a = ctrl_ff[`CTRL_REF_PORT] ? ref_src_a : ref_key_ff;
    fb_a  = ctrl_ff[`CTRL_FB_PORT] ? fb_src_a : ref_key_ff;
    case (ctrl_ff[`CTRL_COMB_HI:`CTRL_COMB_LO])
      `COMB_SRC1: begin
        ref_comb = {1'b0, ref_a};
        fb_comb  = {1'b0, fb_a};
      end
      `COMB_SRC2: begin
        ref_comb = {1'b0, ref_src_b};
        fb_comb  = {1'b0, fb_src_b};
      end
      `COMB_SUM: begin
        ref_comb = {1'b0, ref_a} + {1'b0, ref_src_b};
        fb_comb  = {1'b0, fb_a} + {1'b0, fb_src_b};
      end
      default: begin
        ref_comb = ({1'b0, ref_a} + {1'b0, ref_src_b}) >> 1;
        fb_comb  = ({1'b0, fb_a} + {1'b0, fb_src_b}) >> 1;
      end
    endcase
    ref_sel = ref_comb[16] ? 16'hffff : ref_comb[15:0];
    fb_sel  = fb_comb[16] ? 16'hffff : fb_comb[15:0];
    if (seg_active) begin
      ref_sel = seg_ff[31:16];
    end
    // clamp in real units: upper in low half, lower in high half
    if (ref_sel > ref_lim_ff[15:0]) begin
      ref_clamp = ref_lim_ff[15:0];
    end else if (ref_sel < ref_lim_ff[31:16]) begin
      ref_clamp = ref_lim_ff[31:16];
    end else begin
      ref_clamp = ref_sel;
    end
  end

  // time segment: working-day mask bit per weekday, start inclusive, stop exclusive
  assign seg_active = ctrl_ff[`CTRL_CLOCK_EN] && seg_ff[day_of_week] &&
                      (minute_of_day >= seg_time_ff[10:0]) &&
                      (minute_of_day < seg_time_ff[26:16]);

  pressure_scaler u_ref_scale (
    .clk        (clk),
    .rst_n      (rst_n),
    .value      (ref_clamp),
    .full_scale (scale_ff[15:0]),
    .decimals   (scale_ff[17:16]),
    .pct_ff     (ref_pct)
  );

  pressure_scaler u_fb_scale (
    .clk        (clk),
    .rst_n      (rst_n),
    .value      (fb_sel),
    .full_scale (scale_ff[15:0]),
    .decimals   (scale_ff[17:16]),
    .pct_ff     (pri_fb_pct)
  );

  // tenth-second tick; parameter lets simulation shorten it
  always @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= TICK_CYCLES - 1) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // signed deviation, feedback minus reference, output sense folded in
  assign dev = neg_out ? ($signed({2'b00, ref_pct}) - $signed({2'b00, pri_fb_pct}))
                       : ($signed({2'b00, pri_fb_pct}) - $signed({2'b00, ref_pct}));

  assign sleep_cond =
    (method == `METHOD_FREQ) ? (freq_cmd_ff <= sleep_freq_ff[15:0]) :
    (method == `METHOD_DEV)  ? (dev > $signed({8'h00, sleep_dev_ff[9:0]})) :
    1'b0;

  // timer runs only while running, so the sleep delay restarts after each wake
  tenth_timer u_sleep_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_ff),
    .cond  (sleep_cond && state_ff == ST_RUN),
    .limit (delays_ff[15:0]),
    .done  (sleep_ok)
  );

  // boosted reference: ref + ref*boost/1000, boost signed in tenths of a percent
  assign boost_prod = $signed({2'b00, ref_pct}) * $signed(boost_ff[10:0]);
  assign boost_ref  = $signed({2'b00, ref_pct}) +
                      $signed(boost_prod / $signed(29'sd1000));

  // boost ends early once feedback reaches the boosted reference
  assign boost_reached = neg_out ? ($signed({2'b00, pri_fb_pct}) <= boost_ref)
                                 : ($signed({2'b00, pri_fb_pct}) >= boost_ref);

  tenth_timer u_boost_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_ff),
    .cond  (state_ff == ST_BOOST),
    .limit (boost_ff[31:16]),
    .done  (boost_timeout)
  );

  // wake when feedback falls short of reference by the wake deviation
  assign wake_cond = (-dev) > $signed({8'h00, sleep_dev_ff[25:16]});

  tenth_timer u_wake_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_ff),
    .cond  (wake_cond && state_ff == ST_SLEEP),
    .limit (delays_ff[31:16]),
    .done  (wake_ok)
  );

  // sleep state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (sleep_ok) begin
          nxt_state = ST_BOOST;
        end
      end
      ST_BOOST: begin
        if (boost_reached || boost_timeout) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_ok) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs: boosted reference, frequency command, regulator preset
  always @(posedge clk) begin
    if (!rst_n) begin
      pri_ref_pct_ff    <= 16'h0000;
      freq_cmd_ff       <= 16'h0000;
      run_en_ff         <= 1'b0;
      reg_preset_ff     <= 1'b0;
      reg_preset_val_ff <= 16'h0000;
      ao_out_ff         <= 16'h0000;
    end else begin
      if (state_ff == ST_BOOST) begin
        pri_ref_pct_ff <= boost_ref[28] ? 16'h0000 :
                          ((|boost_ref[27:16]) ? 16'hffff : boost_ref[15:0]);
      end else begin
        pri_ref_pct_ff <= ref_pct;
      end
      reg_preset_ff     <= (state_ff == ST_WAKE);
      reg_preset_val_ff <= sleep_freq_ff[31:16];
      run_en_ff         <= (state_ff != ST_SLEEP);
      if (state_ff == ST_SLEEP) begin
        freq_cmd_ff <= 16'h0000;
      end else if (state_ff == ST_WAKE) begin
        freq_cmd_ff <= sleep_freq_ff[31:16];
      end else if (pri_reg_freq > freq_lim_ff[31:16]) begin
        freq_cmd_ff <= freq_lim_ff[31:16];
      end else if (pri_reg_freq < freq_lim_ff[15:0]) begin
        freq_cmd_ff <= freq_lim_ff[15:0];
      end else begin
        freq_cmd_ff <= pri_reg_freq;
      end
      // secondary regulator never touches the frequency path
      ao_out_ff <= (ao_func_ff == `AO_SEC_REG) ? sec_reg_out : 16'h0000;
    end
  end
endmodule

// ---- rtl/pump_ctrl_defines.vh ----
/*
  Constants of the pump staging and sleep controller: register offsets, field
  positions, reset values, codes and timing.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef PUMP_CTRL_DEFINES_VH
`define PUMP_CTRL_DEFINES_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STAGE       8'h04
`define OFS_SCALE       8'h08
`define OFS_REF_LIM     8'h0c
`define OFS_REF_KEY     8'h10
`define OFS_SLEEP_FREQ  8'h14
`define OFS_SLEEP_DEV   8'h18
`define OFS_DELAYS      8'h1c
`define OFS_BOOST       8'h20
`define OFS_SEG         8'h24
`define OFS_SEG_TIME    8'h28
`define OFS_AO_FUNC     8'h2c
`define OFS_FREQ_LIM    8'h30
`define OFS_STATUS      8'h34
`define OFS_PCT         8'h38

// control and stage register fields
`define CTRL_CLOCK_EN   1
`define CTRL_NEG_OUT    2
`define CTRL_METHOD_LO  3
`define CTRL_METHOD_HI  4
`define CTRL_COMB_LO    5
`define CTRL_COMB_HI    6
`define CTRL_REF_PORT   7
`define CTRL_FB_PORT    8
`define STAGE_ADD_BIT   0
`define STAGE_RED_BIT   1

// reset values (frequency 0.01 Hz, deviation 0.1 %, time 0.1 s)
`define RST_CTRL        32'h0000_0000
`define RST_SCALE       32'h0000_0064
`define RST_REF_LIM     32'h0000_0064
`define RST_SLEEP_FREQ  32'h01f4_01f4
`define RST_SLEEP_DEV   32'h0032_0032
`define RST_DELAYS      32'h0032_0258
`define RST_BOOST       32'h0064_0064
`define RST_FREQ_LIM    32'h1388_0000

// codes
`define METHOD_LOWER    2'h0
`define METHOD_FREQ     2'h1
`define METHOD_DEV      2'h2
`define COMB_SRC1       2'h0
`define COMB_SRC2       2'h1
`define COMB_SUM        2'h2
`define COMB_AVG        2'h3
`define AO_SEC_REG      8'h20
`define PCT_FULL        16'h03e8

// timing: one timer tick is a tenth of a second
`define TENTH_NS        100000000
`define CLK_NS          50
`define TICK_CYCLES     (`TENTH_NS / `CLK_NS)

`endif

// ---- rtl/tenth_timer.v ----
/*
  Qualified delay timer counting tenth-second ticks.
  Assumes a one-cycle tick pulse from the same clock domain.
*/
`timescale 1ns/1ps
module tenth_timer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        tick,
  input  wire        cond,
  input  wire [15:0] limit,
  output wire        done
);
  reg [15:0] cnt_ff;

  // restart whenever the qualifying condition drops; saturate instead of wrap
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else if (!cond) begin
      cnt_ff <= 16'h0000;
    end else if (tick && cnt_ff != 16'hffff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // strictly longer than the limit
  assign done = cond && (cnt_ff > limit);
endmodule

// ---- rtl/pressure_scaler.v ----
/*
  Converts a pressure in real units (with a decimal count) to tenths of a
  percent of the full-scale pressure, registered.
  Assumes full_scale is given in whole units; zero full scale yields zero.
*/
`timescale 1ns/1ps
`include "pump_ctrl_defines.vh"
module pressure_scaler (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [15:0] value,
  input  wire [15:0] full_scale,
  input  wire [1:0]  decimals,
  output reg  [15:0] pct_ff
);
  reg [25:0] p10;
  reg [25:0] num;
  reg [25:0] den;
  reg [25:0] quo;

  // value*1000 / (full_scale * 10^decimals), saturating to 16 bits
  always @* begin
    case (decimals)
      2'h0:    p10 = 26'h1;
      2'h1:    p10 = 26'ha;
      2'h2:    p10 = 26'h64;
      default: p10 = 26'h3e8;
    endcase
    num = {10'h000, value} * {10'h000, `PCT_FULL};
    den = {10'h000, full_scale} * p10;
    quo = (den == 26'h0) ? 26'h0 : num / den;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pct_ff <= 16'h0000;
    end else begin
      pct_ff <= (quo > 26'h000ffff) ? 16'hffff : quo[15:0];
    end
  end
endmodule

// ---- bench/pump_ctrl_props.sv ----
/*
  Port assertions of the pump controller: staging, analog routing, sleep, wake.
  Assumes a bind onto the controller top; single clk domain.
*/
`timescale 1ns/1ps
`include "pump_ctrl_defines.vh"
module pump_ctrl_props (
  input wire        clk,
  input wire        rst_n,
  input wire [7:0]  addr,
  input wire        wr_stb,
  input wire        stage_add,
  input wire        stage_reduce,
  input wire [15:0] sec_reg_out,
  input wire        relay_out_a,
  input wire        relay_out_b,
  input wire        relay_out_c,
  input wire        relay_out_d,
  input wire [15:0] freq_cmd_ff,
  input wire        run_en_ff,
  input wire        reg_preset_ff,
  input wire [15:0] reg_preset_val_ff,
  input wire [15:0] ao_out_ff
);
  // stage writes also move relays, so they mask the pulse step checks
  wire [2:0] cnt = 3'(relay_out_a) + 3'(relay_out_b) + 3'(relay_out_c) + 3'(relay_out_d);
  wire       quiet = !(wr_stb && addr == `OFS_STAGE);
  wire       up = stage_add && !stage_reduce && quiet;
  wire       dn = stage_reduce && !stage_add && quiet;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  relay_order_a: assert property ((!relay_out_b || relay_out_a) &&
    (!relay_out_c || relay_out_b) && (!relay_out_d || relay_out_c))
    else $error("relays not cumulative");
  add_step_a: assert property (up && cnt < 3'd4 |=> cnt == $past(cnt) + 3'd1)
    else $error("add did not close next relay");
  full_hold_a: assert property (up && cnt == 3'd4 |=> cnt == 3'd4)
    else $error("add at full changed relays");
  reduce_step_a: assert property (dn && cnt != 3'd0 |=> cnt == $past(cnt) - 3'd1)
    else $error("reduce did not open top relay");
  relay_hold_a: assert property (quiet && !up && !dn |=> $stable(cnt))
    else $error("relays moved without request");
  ao_route_a: assert property (ao_out_ff != 16'h0 |-> ao_out_ff == $past(sec_reg_out))
    else $error("analog out not secondary output");
  sleep_stop_a: assert property ($fell(run_en_ff) |-> ##[0:1] freq_cmd_ff == 16'h0)
    else $error("sleep entered with frequency running");
  preset_pulse_a: assert property (reg_preset_ff |=> !reg_preset_ff)
    else $error("preset pulse longer than one cycle");
  preset_freq_a: assert property (reg_preset_ff |-> ##[0:1] freq_cmd_ff == reg_preset_val_ff)
    else $error("wake frequency not applied");
  wake_run_a: assert property (reg_preset_ff |-> ##[0:1] run_en_ff)
    else $error("wake without run enable");

  cover property (cnt == 3'd4);
  cover property ($fell(run_en_ff));
  cover property (reg_preset_ff);
endmodule

bind pump_staging_sleep_control pump_ctrl_props u_pump_ctrl_props (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wr_stb(wr_stb), .stage_add(stage_add),
  .stage_reduce(stage_reduce), .sec_reg_out(sec_reg_out), .relay_out_a(relay_out_a),
  .relay_out_b(relay_out_b), .relay_out_c(relay_out_c), .relay_out_d(relay_out_d),
  .freq_cmd_ff(freq_cmd_ff), .run_en_ff(run_en_ff), .reg_preset_ff(reg_preset_ff),
  .reg_preset_val_ff(reg_preset_val_ff), .ao_out_ff(ao_out_ff)
);

// ---- bench/pump_far_side.sv ----
/*
  Far side model: motor contactors and the pressure sensor.
  Assumes relay levels from the controller, pressure demand from the bench.
*/
`timescale 1ns/1ps
module pump_far_side (
  input  wire        clk,
  input  wire [3:0]  coil,
  input  wire [15:0] level,
  output reg  [15:0] sensor_ff,
  output reg  [2:0]  running_ff
);
  // sensor lags one clock, so the controller never sees a same-edge value
  always @(posedge clk) begin
    sensor_ff <= level;
    running_ff <= 3'(coil[0]) + 3'(coil[1]) + 3'(coil[2]) + 3'(coil[3]);
  end
endmodule

// ---- bench/pump_staging_sleep_control_tb.sv ----
/*
  Bench: bus tasks, staging, scaling, segment, sleep and wake sequences.
  Assumes TICK_CYCLES shortened so timers finish in a few cycles.
*/
`timescale 1ns/1ps
`include "pump_ctrl_defines.vh"
module pump_staging_sleep_control_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         wr_stb = 1'b0;
  reg         rd_stb = 1'b0;
  reg         stage_add = 1'b0;
  reg         stage_reduce = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg  [31:0] rdv;
  reg  [15:0] press = 16'h0;
  reg  [15:0] freq = 16'h0;
  reg  [2:0]  day = 3'h2;
  reg  [10:0] minute = 11'h00a;
  wire [31:0] rdata_ff;
  wire [15:0] fb_a, ref_pct, fb_pct, freq_cmd, pre_val, ao;
  wire        ra, rb, rc, rd, run_en, preset;
  wire [2:0]  running;
  wire [3:0]  rly = {rd, rc, rb, ra};
  integer     n_errors = 0;
  integer     n_compared = 0;
  integer     i, n;

  pump_staging_sleep_control #(.TICK_CYCLES(4)) u_pump_staging_sleep_control (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_ff(rdata_ff), .stage_add(stage_add),
    .stage_reduce(stage_reduce), .ref_src_a(16'h0032), .ref_src_b(16'h0010),
    .fb_src_a(fb_a), .fb_src_b(16'h0020), .day_of_week(day),
    .minute_of_day(minute), .pri_reg_freq(freq), .sec_reg_out(16'h1234),
    .relay_out_a(ra), .relay_out_b(rb), .relay_out_c(rc), .relay_out_d(rd),
    .pri_ref_pct_ff(ref_pct), .pri_fb_pct(fb_pct), .freq_cmd_ff(freq_cmd),
    .run_en_ff(run_en), .reg_preset_ff(preset), .reg_preset_val_ff(pre_val),
    .ao_out_ff(ao));
  pump_far_side u_pump_far_side (
    .clk(clk), .coil(rly), .level(press), .sensor_ff(fb_a), .running_ff(running));

  always #25 clk = ~clk;

  task finish_test;
    begin
      if (n_errors == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task settle(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata_ff, exp);
    end
  endtask
  task step(input a, input r);
    begin
      @(posedge clk);
      stage_add <= a;
      stage_reduce <= r;
      @(posedge clk);
      stage_add <= 1'b0;
      stage_reduce <= 1'b0;
      #1;
    end
  endtask
  // bounded wait on run enable (0), preset pulse (1) or reference (2)
  task wait_sig(input [1:0] sel, input [15:0] val);
    begin
      n = 0;
      while ((((sel == 2'd2) ? ref_pct : {15'h0, sel[0] ? preset : run_en}) !== val)
             && n < 400) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      if (n >= 400) begin
        chk(n, 0);
        finish_test;
      end
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`OFS_CTRL, `RST_CTRL);
    rdchk(`OFS_SCALE, `RST_SCALE);
    rdchk(`OFS_REF_LIM, `RST_REF_LIM);
    rdchk(`OFS_SLEEP_FREQ, `RST_SLEEP_FREQ);
    rdchk(`OFS_SLEEP_DEV, `RST_SLEEP_DEV);
    rdchk(`OFS_DELAYS, `RST_DELAYS);
    rdchk(`OFS_BOOST, `RST_BOOST);
    rdchk(`OFS_FREQ_LIM, `RST_FREQ_LIM);
    rdchk(8'hfc, 32'h0);
    // five adds, the last refused at full, then both together do nothing
    for (i = 1; i <= 5; i = i + 1) begin
      step(1'b1, 1'b0);
      chk(rly, 4'hf >> (4 - (i > 4 ? 4 : i)));
    end
    step(1'b1, 1'b1);
    chk(rly, 4'hf);
    settle(1);
    chk(running, 3'h4);
    for (i = 1; i <= 5; i = i + 1) begin
      step(1'b0, 1'b1);
      chk(rly, 4'hf >> (i > 4 ? 4 : i));
    end
    wr(`OFS_STAGE, 32'h1);
    settle(1);
    chk(rly, 4'h1);
    wr(`OFS_STAGE, 32'h2);
    settle(1);
    chk(rly, 4'h0);
    // analog out carries the secondary output only at its own code
    wr(`OFS_AO_FUNC, 32'h1f);
    settle(3);
    chk(ao, 16'h0);
    wr(`OFS_AO_FUNC, {24'h0, `AO_SEC_REG});
    settle(3);
    chk(ao, 16'h1234);
    // keyed reference scaled and clamped, feedback from port one
    wr(`OFS_CTRL, 32'h100);
    press <= 16'h0019;
    wr(`OFS_REF_KEY, 32'h32);
    settle(6);
    chk(ref_pct, 16'h01f4);
    chk(fb_pct, 16'h00fa);
    rdchk(`OFS_PCT, 32'h00fa_01f4);
    wr(`OFS_SCALE, 32'h0001_0064);
    settle(6);
    chk(ref_pct, 16'h0032);
    wr(`OFS_SCALE, `RST_SCALE);
    wr(`OFS_REF_KEY, 32'h96);
    settle(6);
    chk(ref_pct, `PCT_FULL);
    wr(`OFS_REF_KEY, 32'h32);
    // reference from port one, both sources summed
    wr(`OFS_CTRL, 32'h1c0);
    settle(6);
    chk(ref_pct, 16'h0294);
    chk(fb_pct, 16'h023a);
    // segment pressure replaces the reference inside its window only
    wr(`OFS_SEG, 32'h0050_007f);
    wr(`OFS_SEG_TIME, 32'h03e8_0000);
    wr(`OFS_CTRL, 32'h102);
    settle(6);
    chk(ref_pct, 16'h0320);
    @(posedge clk);
    minute <= 11'h4b0;
    settle(6);
    chk(ref_pct, 16'h01f4);
    // lower-limit method clamps frequency and never sleeps
    wr(`OFS_FREQ_LIM, 32'h1388_0100);
    wr(`OFS_CTRL, 32'h100);
    freq <= 16'h2000;
    settle(4);
    chk(freq_cmd, 16'h1388);
    @(posedge clk);
    freq <= 16'h0050;
    settle(60);
    chk(freq_cmd, 16'h0100);
    chk(run_en, 1'b1);
    // frequency sleep: above start frequency it never sleeps
    wr(`OFS_DELAYS, 32'h0002_0002);
    wr(`OFS_BOOST, 32'h0003_0064);
    press <= 16'h0;
    freq <= 16'h0400;
    wr(`OFS_CTRL, 32'h108);
    settle(60);
    chk(run_en, 1'b1);
    @(posedge clk);
    freq <= 16'h0064;
    // boosted reference is 500 plus a tenth of it; feedback never reaches it
    wait_sig(2'd2, 16'h0226);
    chk(n >= 10, 1'b1);
    wait_sig(2'd0, 16'h0);
    chk(n >= 12 && n <= 18, 1'b1);
    settle(1);
    chk(freq_cmd, 16'h0);
    wait_sig(2'd1, 16'h1);
    chk(pre_val, 16'h01f4);
    settle(2);
    chk(run_en, 1'b1);
    // deviation sleep on high feedback, wake only once it drops
    @(posedge clk);
    freq <= 16'h0400;
    press <= 16'h005a;
    wr(`OFS_CTRL, 32'h110);
    wait_sig(2'd0, 16'h0);
    settle(60);
    chk(run_en, 1'b0);
    @(posedge clk);
    press <= 16'h0;
    wait_sig(2'd1, 16'h1);
    chk(pre_val, 16'h01f4);
    // negative output: low feedback sleeps, high feedback wakes
    wr(`OFS_CTRL, 32'h114);
    wait_sig(2'd0, 16'h0);
    settle(30);
    chk(run_en, 1'b0);
    @(posedge clk);
    press <= 16'h005a;
    wait_sig(2'd1, 16'h1);
    chk(freq_cmd, 16'h01f4);
    finish_test;
  end
endmodule
